//--- src/eprom_host_pkg.sv
// constants and carrier types for the eprom programmer / reader controller
// assumes a 50 MHz system clock; voltage levels are driven by external switches
package eprom_host_pkg;
  localparam int ADDR_W           = 14;
  localparam int DATA_W           = 8;
  localparam int CLK_NS           = 20;
  // programming set-up time before the strobe falls, in ns
  localparam int SETUP_NS         = 2000;
  localparam int SETUP_CYC        = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  // nominal program pulse, in ns
  localparam int PULSE_NS         = 100000;
  localparam int PULSE_CYC        = PULSE_NS / CLK_NS;
  // read access allowance, in ns
  localparam int ACCESS_NS        = 200;
  localparam int ACCESS_CYC       = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  // output float allowance after deselect, in ns
  localparam int FLOAT_NS         = 50;
  localparam int FLOAT_CYC        = (FLOAT_NS + CLK_NS - 1) / CLK_NS;
  localparam int MAX_TRIES        = 25;
  localparam logic [7:0] ERASED   = 8'hff;

  typedef enum logic [1:0] {
    OP_READ, OP_PROG, OP_SIG
  } op_t;

  typedef struct packed {
    op_t               op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } req_t;

  typedef struct packed {
    logic              sel_n;
    logic              gate_n;
    logic              strobe_n;
    logic              vpp_hi;
    logic              id_hv;
  } ctl_t;
endpackage

//--- src/eprom_host.sv
// host controller that reads, programs and signature-reads a uv eprom
// assumes the eprom pins are wired straight to the ports; vpp_hi and id_hv
// steer external high-voltage switches; inputs synchronous to sys_clk_i
`timescale 1ns/1ns
module eprom_host
  import eprom_host_pkg::*;
#(
  parameter int PULSE_CYCLES = PULSE_CYC,
  parameter int TRIES        = MAX_TRIES
)(
  // clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              nrst_i,
  // request side
  input  wire logic              req_valid_i,
  input  wire req_t              req_i,
  output logic                   req_ready_o,
  output logic                   done_o,
  output logic                   fail_o,
  output logic [DATA_W-1:0]      rdata_o,
  // eprom pins
  output logic [ADDR_W-1:0]      addr_o,
  input  wire logic [DATA_W-1:0] data_i,
  output logic [DATA_W-1:0]      data_o,
  output logic                   data_oe_o,
  output ctl_t                   ctl_o
);
  // the pulse count must fit the 17-bit counter, the tries the 8-bit one
  if (PULSE_CYCLES < 1 || PULSE_CYCLES > 131071 || TRIES < 1 || TRIES > 255)
  begin
    $error("eprom_host: bad parameter");
  end

  typedef enum {
    S_IDLE, S_SETUP, S_PULSE, S_VREC, S_VWAIT, S_ACC, S_FLOAT
  } state_t;

  state_t              state_r;
  logic [16:0]         cnt_r;
  logic [7:0]          tries_r;
  op_t                 op_r;
  logic [DATA_W-1:0]   want_r;

  // cycles that select, supply and data have stood before the strobe falls
  logic [16:0]         setup_seen_r;

  // true when the verified byte equals the wanted byte
  function automatic logic match(input logic [DATA_W-1:0] got,
                                 input logic [DATA_W-1:0] want);
    match = (got == want);
  endfunction

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_r     <= S_IDLE;
      cnt_r       <= '0;
      tries_r     <= '0;
      op_r        <= OP_READ;
      want_r      <= ERASED;
      req_ready_o <= 1'b0;
      done_o      <= 1'b0;
      fail_o      <= 1'b0;
      rdata_o     <= '0;
      addr_o      <= '0;
      data_o      <= '0;
      data_oe_o   <= 1'b0;
      ctl_o       <= '{sel_n: 1'b1, gate_n: 1'b1, strobe_n: 1'b1,
                       vpp_hi: 1'b0, id_hv: 1'b0};
    end
    else
    begin
      done_o <= 1'b0;
      case (state_r)
        S_IDLE:
        begin
          req_ready_o <= 1'b1;
          if (req_valid_i && req_ready_o)
          begin
            req_ready_o <= 1'b0;
            op_r        <= req_i.op;
            want_r      <= req_i.data;
            addr_o      <= req_i.addr;
            fail_o      <= 1'b0;
            tries_r     <= '0;
            ctl_o.sel_n <= 1'b0;
            if (req_i.op == OP_PROG)
            begin
              data_o        <= req_i.data;
              data_oe_o     <= 1'b1;
              ctl_o.vpp_hi  <= 1'b1;
              cnt_r         <= 17'(SETUP_CYC);
              state_r       <= S_SETUP;
            end
            else
            begin
              ctl_o.id_hv  <= (req_i.op == OP_SIG);
              ctl_o.gate_n <= 1'b0;
              cnt_r        <= 17'(ACCESS_CYC);
              state_r      <= S_ACC;
            end
          end
        end
        S_SETUP:
        begin
          // on a retry the host drives data again only once the outputs
          // have floated, still a full set-up before the strobe
          if (!data_oe_o && cnt_r <= 17'(SETUP_CYC) + 17'd1)
            data_oe_o <= 1'b1;
          if (cnt_r <= 17'd1)
          begin
            ctl_o.strobe_n <= 1'b0;
            cnt_r          <= 17'(PULSE_CYCLES);
            tries_r        <= tries_r + 8'd1;
            state_r        <= S_PULSE;
          end
          else
            cnt_r <= cnt_r - 17'd1;
        end
        S_PULSE:
        begin
          if (cnt_r <= 17'd1)
          begin
            ctl_o.strobe_n <= 1'b1;
            data_oe_o      <= 1'b0;
            cnt_r          <= 17'(FLOAT_CYC);
            state_r        <= S_VREC;
          end
          else
            cnt_r <= cnt_r - 17'd1;
        end
        S_VREC:
        begin
          if (cnt_r <= 17'd1)
          begin
            ctl_o.gate_n <= 1'b0;
            cnt_r        <= 17'(ACCESS_CYC);
            state_r      <= S_VWAIT;
          end
          else
            cnt_r <= cnt_r - 17'd1;
        end
        S_VWAIT:
        begin
          if (cnt_r <= 17'd1)
          begin
            ctl_o.gate_n <= 1'b1;
            rdata_o      <= data_i;
            // stop on match, never an extra pulse
            if (match(data_i, want_r) || tries_r >= 8'(TRIES))
            begin
              fail_o       <= !match(data_i, want_r);
              ctl_o.sel_n  <= 1'b1;
              ctl_o.vpp_hi <= 1'b0;
              cnt_r        <= 17'(FLOAT_CYC);
              state_r      <= S_FLOAT;
            end
            else
            begin
              cnt_r     <= 17'(FLOAT_CYC) + 17'(SETUP_CYC);
              state_r   <= S_SETUP;
            end
          end
          else
            cnt_r <= cnt_r - 17'd1;
        end
        S_ACC:
        begin
          if (cnt_r <= 17'd1)
          begin
            rdata_o      <= data_i;
            ctl_o.gate_n <= 1'b1;
            ctl_o.sel_n  <= 1'b1;
            ctl_o.id_hv  <= 1'b0;
            cnt_r        <= 17'(FLOAT_CYC);
            state_r      <= S_FLOAT;
          end
          else
            cnt_r <= cnt_r - 17'd1;
        end
        S_FLOAT:
        begin
          if (cnt_r <= 17'd1)
          begin
            done_o  <= 1'b1;
            state_r <= S_IDLE;
          end
          else
            cnt_r <= cnt_r - 17'd1;
        end
        default:
          state_r <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      setup_seen_r <= '0;
    else if (!ctl_o.sel_n && ctl_o.vpp_hi && data_oe_o && ctl_o.strobe_n)
      setup_seen_r <= setup_seen_r + 17'd1;
    else
      setup_seen_r <= '0;
  end

  // program strobe only with select low and supply high
  chk_strobe_needs_vpp: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    !ctl_o.strobe_n |-> (!ctl_o.sel_n && ctl_o.vpp_hi))
    else $error("strobe low without select or vpp");

  chk_strobe_setup: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    $fell(ctl_o.strobe_n) |->
      setup_seen_r >= 17'(SETUP_CYC))
    else $error("strobe fell without set-up");

  chk_no_contention: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    data_oe_o |-> ctl_o.gate_n)
    else $error("host drives data while gate low");

  chk_data_held_pulse: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    !ctl_o.strobe_n |-> $stable(data_o) && $stable(addr_o))
    else $error("data or address moved during pulse");

  chk_tries_bound: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    tries_r <= 8'(TRIES))
    else $error("too many program pulses");

  chk_no_overprog: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    (state_r == S_VWAIT && cnt_r == 17'd1 && match(data_i, want_r))
      |=> state_r == S_FLOAT)
    else $error("pulse after passing verify");

  chk_sig_gate: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    ctl_o.id_hv |-> (!ctl_o.sel_n && !ctl_o.vpp_hi))
    else $error("id voltage outside signature read");

  chk_verify_strobe: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    (ctl_o.vpp_hi && !ctl_o.gate_n) |-> ctl_o.strobe_n)
    else $error("gate and strobe low together");

  cov_read: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
    state_r == S_ACC && op_r == OP_READ);
  cov_sig: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
    state_r == S_ACC && op_r == OP_SIG);
  cov_prog_ok: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
    done_o && op_r == OP_PROG && !fail_o);
  cov_retry: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
    tries_r == 8'd2);
endmodule

//--- tb/eprom_model.sv
// behavioural uv eprom: array, program, verify, signature codes
// assumes host pins wired straight; undriven bus shows a moving pattern
`timescale 1ns/1ns
module eprom_model
  import eprom_host_pkg::*;
#(
  parameter logic [7:0] MFR = 8'h3c, // arbitrary
  parameter logic [7:0] DEV = 8'h5b  // arbitrary
)(
  input  wire logic              clk_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] host_d_i,
  input  wire logic              host_oe_i,
  input  wire ctl_t              ctl_i,
  input  wire logic [3:0]        need_i,
  output logic [DATA_W-1:0]      data_o
);
  logic [7:0] mem [0:16383];
  logic [7:0] flt_r = 8'ha5;
  int         hits = 0;
  initial foreach (mem[i]) mem[i] = ERASED;
  always @(posedge clk_i) flt_r <= {flt_r[6:0], ~flt_r[7]};
  always @(posedge ctl_i.sel_n) hits = 0;
  // a slow cell takes only after need_i pulses
  always @(negedge ctl_i.strobe_n)
    if (!ctl_i.sel_n && ctl_i.vpp_hi && host_oe_i)
    begin
      hits = hits + 1;
      if (hits >= need_i)
        mem[addr_i] = mem[addr_i] & host_d_i;
    end
  always_comb
    if (ctl_i.sel_n || ctl_i.gate_n || !ctl_i.strobe_n)
      data_o = host_oe_i ? host_d_i : flt_r;
    else if (ctl_i.id_hv && !ctl_i.vpp_hi)
      data_o = addr_i[0] ? DEV : MFR;
    else
      data_o = mem[addr_i];
endmodule

//--- tb/eprom_host_tb_top.sv
// self-checking bench for the eprom host controller
// assumes the eprom model on the pins; short pulse and four tries
`timescale 1ns/1ns
module eprom_host_tb_top;
  import eprom_host_pkg::*;
  localparam logic [7:0] MFR = 8'h3c;
  localparam logic [7:0] DEV = 8'h5b;
  localparam int         TRIES_TB = 4;
  logic [7:0]        exp_p;
  logic              sys_clk_i = 1'b0;
  logic              nrst_i = 1'b0;
  logic              req_valid_i = 1'b0;
  req_t              req_i = '0;
  logic              req_ready_o, done_o, fail_o, data_oe_o;
  logic [DATA_W-1:0] rdata_o, data_o, data_i, d, e;
  logic [ADDR_W-1:0] addr_o, a;
  ctl_t              ctl_o;
  logic [3:0]        need = 4'd1;
  logic              bad;
  logic [7:0]        sh [logic [13:0]];
  int                num_errors = 0;
  int                n_checks = 0;
  int                pulses = 0;
  int                su = 0;
  always #10 sys_clk_i = ~sys_clk_i;
  eprom_host #(.PULSE_CYCLES(20), .TRIES(TRIES_TB)) dut_u (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .req_ready_o(req_ready_o), .done_o(done_o), .fail_o(fail_o),
    .rdata_o(rdata_o), .addr_o(addr_o), .data_i(data_i), .data_o(data_o),
    .data_oe_o(data_oe_o), .ctl_o(ctl_o));
  eprom_model #(.MFR(MFR), .DEV(DEV)) dev_u (.clk_i(sys_clk_i),
    .addr_i(addr_o), .host_d_i(data_o), .host_oe_i(data_oe_o),
    .ctl_i(ctl_o), .need_i(need), .data_o(data_i));
  function automatic logic [7:0] rd(input logic [13:0] x);
    return sh.exists(x) ? sh[x] : ERASED;
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic op(input op_t o, input logic [13:0] ad, input logic [7:0] dt);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    req_valid_i <= 1'b1;
    req_i <= '{o, ad, dt};
    do @(negedge sys_clk_i); while (req_ready_o !== 1'b1 && ++n < 50);
    if (req_ready_o !== 1'b1)
      n = 3000;
    @(posedge sys_clk_i);
    req_valid_i <= 1'b0;
    do @(negedge sys_clk_i); while (done_o !== 1'b1 && ++n < 3000);
    if (n >= 3000)
    begin
      num_errors++;
      finish_test();
    end
  endtask
  // set-up time with strobe high before each pulse
  always @(posedge sys_clk_i)
    su <= (ctl_o.sel_n || !ctl_o.vpp_hi || !data_oe_o || !ctl_o.strobe_n)
          ? 0 : su + 1;
  always @(negedge ctl_o.strobe_n)
  begin
    pulses++;
    check(8'(su >= SETUP_CYC - 1), 8'h01);
  end
  initial
  begin
    void'($urandom(32'hb209e529));
    repeat (12) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    for (int j = 0; j < 2; j++)
    begin
      op(OP_SIG, 14'(j), 8'h00);
      check(rdata_o, j ? DEV : MFR);
    end
    $display("signature test done");
    // slow cells, a rewrite to ones and a cell that never takes
    for (int i = 0; i < 8; i++)
    begin
      if (i != 6)
        a = 14'($urandom);
      d = (i == 6) ? ERASED : 8'($urandom);
      need = (i == 7) ? 4'd5 : 4'(i % 4 + 1);
      e = rd(a);
      bad = ((e & d) != d) || (need > 4 && e != d);
      exp_p = bad ? 8'(TRIES_TB) : ((e == d) ? 8'h01 : 8'(need));
      pulses = 0;
      op(OP_PROG, a, d);
      check(fail_o, bad);
      check(8'(pulses), exp_p);
      if (need <= 4)
        sh[a] = e & d;
      op(OP_READ, a, 8'h00);
      check(rdata_o, rd(a));
      op(OP_READ, a ^ 14'h1, 8'h00);
      check(rdata_o, rd(a ^ 14'h1));
      $display("test %0d done", i);
    end
    finish_test();
  end
endmodule
